//--- rcs_cfg.svh
// Fixed sizes and reset values for the completion output stream
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

`define RCS_DATA_W      256
`define RCS_SIDE_W      75
`define RCS_MASK_W      8
`define RCS_DWC_W       4
`define RCS_DWORD_W     32
`define RCS_MASK_256    8'hff
`define RCS_MASK_128    8'h0f
`define RCS_MASK_64     8'h03
`define RCS_READY_RST   1'b0
`define RCS_VALID_RST   1'b0

`endif

//--- rcs_pkg.sv
// Types and shared helpers for the completion output stream
`include "rcs_cfg.svh"

package rcs_pkg;

	typedef enum logic [2:0] {
		RCS_W64  = 3'h1,
		RCS_W128 = 3'h2,
		RCS_W256 = 3'h4
	} rcs_width_t;

	typedef enum logic [2:0] {
		RCS_ST_EMPTY = 3'h1,
		RCS_ST_ONE   = 3'h2,
		RCS_ST_TWO   = 3'h4
	} rcs_state_t;

	// Beat offered by the link-side core
	typedef struct packed {
		logic [`RCS_DATA_W-1:0] payload;
		logic [`RCS_SIDE_W-1:0] sideband;
		logic                   pkt_end;
		logic [`RCS_DWC_W-1:0]  dw_count;
	} rcs_src_t;

	// Beat as presented to the consumer
	typedef struct packed {
		logic [`RCS_DATA_W-1:0] payload;
		logic [`RCS_SIDE_W-1:0] sideband;
		logic                   pkt_end;
		logic [`RCS_MASK_W-1:0] dword_mask;
	} rcs_beat_t;

	// Dwords that exist at a given bus width
	function automatic logic [`RCS_MASK_W-1:0] rcs_width_mask(
		input rcs_width_t w
	);
		case (w)
			RCS_W64:  rcs_width_mask = `RCS_MASK_64;
			RCS_W128: rcs_width_mask = `RCS_MASK_128;
			default:  rcs_width_mask = `RCS_MASK_256;
		endcase
	endfunction

	// True when a mask is a run of ones from bit 0
	function automatic logic rcs_is_contig(input logic [`RCS_MASK_W-1:0] m);
		logic [`RCS_MASK_W-1:0] inc;
		inc = m + 8'h01;
		rcs_is_contig = ((m & inc) == 8'h00);
	endfunction

endpackage

//--- rcs_beat_fmt.sv
// Shapes one source beat into the consumer beat format
`timescale 1ns/100ps

`include "rcs_cfg.svh"

module rcs_beat_fmt (
	input  wire rcs_pkg::rcs_src_t   src_i,
	input  wire rcs_pkg::rcs_width_t width_i,
	input  wire logic                straddle_i,
	output rcs_pkg::rcs_beat_t       beat_o
);
	import rcs_pkg::*;

	logic                    strad;
	logic [`RCS_MASK_W-1:0]  wmask;
	logic [`RCS_MASK_W:0]    ones;
	logic [`RCS_MASK_W-1:0]  tail;
	logic [`RCS_DATA_W-1:0]  pmask;

	always_comb begin
		strad = straddle_i && (width_i == RCS_W256);
		wmask = rcs_width_mask(width_i);
		ones  = (9'h001 << src_i.dw_count) - 9'h001;
		if (src_i.dw_count == 4'h0 || src_i.dw_count > 4'h8) begin
			tail = `RCS_MASK_256;
		end else begin
			tail = ones[`RCS_MASK_W-1:0];
		end
		for (int i = 0; i < `RCS_MASK_W; i++) begin
			pmask[i*`RCS_DWORD_W +: `RCS_DWORD_W] = {`RCS_DWORD_W{wmask[i]}};
		end
		beat_o.payload  = src_i.payload & pmask;
		beat_o.sideband = src_i.sideband;
		if (strad) begin
			beat_o.pkt_end    = 1'b0;
			beat_o.dword_mask = `RCS_MASK_256;
		end else begin
			beat_o.pkt_end = src_i.pkt_end;
			if (src_i.pkt_end) begin
				beat_o.dword_mask = tail & wmask;
			end else begin
				beat_o.dword_mask = wmask;
			end
			beat_o.dword_mask = beat_o.dword_mask & wmask;
		end
	end
endmodule

//--- rcs_stream_out.sv
// Completion output stream: two-entry registered master stage
`timescale 1ns/100ps

`include "rcs_cfg.svh"

module rcs_stream_out (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire rcs_pkg::rcs_width_t width_i,
	input  wire logic                straddle_i,
	input  wire logic                src_valid_i,
	input  wire rcs_pkg::rcs_src_t   src_i,
	output logic                     src_ready_o,
	output logic [255:0]             completion_stream_payload_o,
	output logic [74:0]              completion_sideband_o,
	output logic                     completion_packet_end_o,
	output logic [7:0]               completion_dword_mask_o,
	output logic                     completion_out_valid_o,
	input  wire logic                completion_consumer_ready_i
);
	import rcs_pkg::*;

	rcs_beat_t  fmt;
	rcs_beat_t  main_q;
	rcs_beat_t  main_d;
	rcs_beat_t  skid_q;
	rcs_beat_t  skid_d;
	rcs_state_t st_q;
	rcs_state_t st_d;
	logic       rdy_q;
	logic       rdy_d;
	logic       valid_q;
	logic       valid_d;
	logic       live_q;
	logic       in_pkt_q;
	logic       in_pkt_d;
	logic       take;
	logic       pop;

	rcs_beat_fmt rcs_beat_fmt_inst (
		.width_i    (width_i),
		.straddle_i (straddle_i),
		.src_i      (src_i),
		.beat_o     (fmt)
	);

	assign take = src_valid_i && rdy_q;
	assign pop  = (st_q != RCS_ST_EMPTY) && completion_consumer_ready_i;

	always_comb begin
		main_d   = main_q;
		skid_d   = skid_q;
		st_d     = st_q;
		in_pkt_d = in_pkt_q;
		case (st_q)
			RCS_ST_EMPTY: begin
				if (take) begin
					main_d = fmt;
					st_d   = RCS_ST_ONE;
				end
			end
			RCS_ST_ONE: begin
				if (pop && take) begin
					main_d = fmt;
				end else if (pop) begin
					st_d = RCS_ST_EMPTY;
				end else if (take) begin
					skid_d = fmt;
					st_d   = RCS_ST_TWO;
				end
			end
			RCS_ST_TWO: begin
				if (pop) begin
					main_d = skid_q;
					st_d   = RCS_ST_ONE;
				end
			end
			default: begin
				st_d = RCS_ST_EMPTY;
			end
		endcase
		if (pop) begin
			in_pkt_d = !main_q.pkt_end;
		end
		rdy_d = live_q && (st_d != RCS_ST_TWO);
		valid_d = st_d != RCS_ST_EMPTY;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q     <= RCS_ST_EMPTY;
			rdy_q    <= `RCS_READY_RST;
			valid_q  <= `RCS_VALID_RST;
			live_q   <= 1'b0;
			in_pkt_q <= 1'b0;
			main_q   <= '0;
			skid_q   <= '0;
		end else begin
			st_q     <= st_d;
			rdy_q    <= rdy_d;
			valid_q  <= valid_d;
			live_q   <= 1'b1;
			in_pkt_q <= in_pkt_d;
			main_q   <= main_d;
			skid_q   <= skid_d;
		end
	end

	assign src_ready_o                 = rdy_q;
	assign completion_out_valid_o      = valid_q;
	assign completion_stream_payload_o = main_q.payload;
	assign completion_sideband_o       = main_q.sideband;
	assign completion_packet_end_o     = main_q.pkt_end;
	assign completion_dword_mask_o     = main_q.dword_mask;

	logic       strad_a;
	logic [7:0] wm_a;
	assign strad_a = straddle_i && (width_i == RCS_W256);
	assign wm_a    = rcs_width_mask(width_i);

	a_hold_when_stalled: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		completion_out_valid_o && !completion_consumer_ready_i
		|=> completion_out_valid_o && $stable(main_q))
		else $error("Output changed while stalled");

	a_reset_valid_low: assert property (
		@(posedge clk_i)
		!rst_n_i |=> !completion_out_valid_o ##1 !completion_out_valid_o)
		else $error("Valid rose too early after reset");

	a_straddle_end_low: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		strad_a && $stable(straddle_i) && $past(strad_a) &&
		completion_out_valid_o |-> !completion_packet_end_o)
		else $error("Packet end used in straddle mode");

	a_straddle_mask_ones: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		strad_a && $past(strad_a) && $past(strad_a, 2) &&
		completion_out_valid_o |-> completion_dword_mask_o == 8'hff)
		else $error("Mask not all ones in straddle mode");

	a_mask_narrow_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$stable(width_i) && $past(width_i) == $past(width_i, 2) &&
		completion_out_valid_o |-> (completion_dword_mask_o & ~wm_a) == 8'h00)
		else $error("Unused mask bits set");

	a_mask_contig: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		completion_out_valid_o |->
		rcs_is_contig(completion_dword_mask_o) &&
		completion_dword_mask_o != 8'h00)
		else $error("Mask not contiguous");

	a_mask_full_mid: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!strad_a && $stable(width_i) && $past(width_i) == $past(width_i, 2) &&
		completion_out_valid_o && !completion_packet_end_o
		|-> completion_dword_mask_o == wm_a)
		else $error("Mask short on a non-final beat");

	a_payload_upper_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		width_i == RCS_W64 && $past(width_i == RCS_W64) &&
		$past(width_i == RCS_W64, 2) && completion_out_valid_o
		|-> completion_stream_payload_o[255:64] == 192'h0)
		else $error("Upper payload bits not zero");

	a_payload_mid_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		width_i == RCS_W128 && $past(width_i == RCS_W128) &&
		$past(width_i == RCS_W128, 2) && completion_out_valid_o
		|-> completion_stream_payload_o[255:128] == 128'h0)
		else $error("Payload bits above 128 not zero");

	a_valid_in_packet: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		in_pkt_q && !strad_a && $past(src_valid_i)
		|-> completion_out_valid_o)
		else $error("Valid dropped inside a fed packet");

	a_src_end_passes: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!strad_a && $past(!strad_a) && st_q == RCS_ST_EMPTY && take
		|=> completion_out_valid_o &&
		completion_packet_end_o == $past(src_i.pkt_end))
		else $error("Packet end lost on its beat");

	a_ready_blocks_full: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == RCS_ST_TWO |-> !src_ready_o)
		else $error("Ready while both stages full");

	c_single_beat: cover property (
		@(posedge clk_i) disable iff (!rst_n_i)
		pop && completion_packet_end_o && !in_pkt_q);

	c_stall_then_go: cover property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(completion_out_valid_o && !completion_consumer_ready_i) [*3]
		##1 pop);

	c_skid_full: cover property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == RCS_ST_TWO ##1 pop);

	c_multi_beat: cover property (
		@(posedge clk_i) disable iff (!rst_n_i)
		pop && !completion_packet_end_o ##[1:4]
		pop && completion_packet_end_o);
endmodule

//--- rcs_consumer_model.sv
// Consumer model that paces the completion stream
`timescale 1ns/100ps

module rcs_consumer_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] pace_i,
	output logic            ready_o
);
	// Ready moves between edges only
	always @(negedge clk_i) begin
		case (pace_i)
			2'h0: ready_o <= 1'b1;
			2'h1: ready_o <= 1'($urandom_range(1));
			default: ready_o <= 1'b0;
		endcase
	end
endmodule

//--- rcs_stream_out_tb_top.sv
// Self-checking bench for the completion output stream
`timescale 1ns/100ps

module rcs_stream_out_tb_top;
	import rcs_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_n_i = 1'b0;
	rcs_width_t   width_i = RCS_W256;
	logic         straddle_i = 1'b0;
	logic         src_valid_i = 1'b0;
	rcs_src_t     src_i = '0;
	logic         src_ready_o, pend, vld, rdy;
	logic [255:0] pay;
	logic [74:0]  side;
	logic [7:0]   mask;
	logic [1:0]   pace = 2'h0;
	logic         pv = 1'b0, pr = 1'b0, r1 = 1'b1, r2 = 1'b1;
	rcs_beat_t    got, prev, expq[$];
	int           num_errors = 0;
	int           compares = 0;

	always #5 clk_i = ~clk_i;

	rcs_stream_out rcs_stream_out_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .width_i(width_i),
		.straddle_i(straddle_i), .src_valid_i(src_valid_i), .src_i(src_i),
		.src_ready_o(src_ready_o), .completion_stream_payload_o(pay),
		.completion_sideband_o(side), .completion_packet_end_o(pend),
		.completion_dword_mask_o(mask), .completion_out_valid_o(vld),
		.completion_consumer_ready_i(rdy)
	);
	rcs_consumer_model rcs_consumer_model_inst (
		.clk_i(clk_i), .pace_i(pace), .ready_o(rdy)
	);

	assign got = {pay, side, pend, mask};

	function automatic rcs_beat_t exp_beat(rcs_src_t s);
		rcs_beat_t  b;
		logic [7:0] wm;
		wm = width_i == RCS_W64 ? 8'h03 : width_i == RCS_W128 ? 8'h0f : 8'hff;
		b = {s.payload, s.sideband, s.pkt_end, wm};
		for (int i = 0; i < 8; i++)
			if (!wm[i]) b.payload[32*i +: 32] = 32'h0;
		if (s.pkt_end && s.dw_count inside {[4'h1:4'h8]})
			b.dword_mask = wm & (8'hff >> (4'h8 - s.dw_count));
		if (straddle_i && width_i == RCS_W256) begin
			b.pkt_end = 1'b0;
			b.dword_mask = 8'hff;
		end
		return b;
	endfunction

	task automatic chk_beat(string n, rcs_beat_t e, rcs_beat_t g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic chk_bit(string n, logic e, logic g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %b got %b", n, e, g);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic hang();
		num_errors++;
		$display("mismatch wait_bound exp done got stuck");
		give_verdict();
	endtask

	// Output side: compare taken beats, held beats and reset state
	always @(posedge clk_i) begin
		if (!r1 || !r2) chk_bit("valid_in_reset", 1'b0, vld);
		if (pv && !pr && r1) begin
			chk_bit("valid_held", 1'b1, vld);
			chk_beat("held_beat", prev, got);
		end
		if (vld && rdy) begin
			if (expq.size() == 0) chk_bit("extra_beat", 1'b0, vld);
			else chk_beat("beat", expq.pop_front(), got);
		end
		r2 <= r1;
		r1 <= rst_n_i;
		pv <= vld;
		pr <= rdy;
		prev <= got;
	end

	task automatic send(rcs_src_t s);
		int k;
		src_valid_i = 1'b1;
		src_i = s;
		k = 0;
		while (src_ready_o !== 1'b1 && k < 200) begin
			@(negedge clk_i);
			k++;
		end
		if (src_ready_o !== 1'b1) hang();
		expq.push_back(exp_beat(s));
		@(negedge clk_i);
	endtask

	task automatic packet(int n);
		rcs_src_t s;
		int       nd;
		nd = width_i == RCS_W64 ? 2 : width_i == RCS_W128 ? 4 : 8;
		for (int b = 0; b < n; b++) begin
			s.payload = {8{$urandom}};
			s.sideband = 75'({$urandom, $urandom, $urandom});
			s.pkt_end = (b == n - 1);
			s.dw_count = 4'($urandom_range(nd + 1, 0));
			if (straddle_i) begin
				s.sideband[32] = (b == 0);
				s.sideband[34] = (b == n - 1);
			end
			send(s);
		end
	endtask

	initial begin
		rcs_width_t wl[4] = '{RCS_W64, RCS_W128, RCS_W256, RCS_W256};
		int         k;
		void'($urandom(58392));
		for (int c = 0; c < 4; c++) begin
			@(negedge clk_i);
			rst_n_i = 1'b0;
			src_valid_i = 1'b0;
			width_i = wl[c];
			straddle_i = 1'(c == 3);
			pace = 2'h0;
			repeat (6) @(negedge clk_i);
			rst_n_i = 1'b1;
			repeat (3) @(negedge clk_i);
			pace = 2'h2;
			packet(2);
			src_valid_i = 1'b0;
			repeat (3) @(negedge clk_i);
			chk_bit("stage_full", 1'b0, src_ready_o);
			pace = 2'h1;
			for (int p = 0; p < 40; p++) packet(int'($urandom_range(3, 1)));
			pace = 2'h0;
			packet(1);
			packet(4);
			src_valid_i = 1'b0;
			k = 0;
			while (expq.size() != 0 && k < 100) begin
				@(negedge clk_i);
				k++;
			end
			if (expq.size() != 0) hang();
		end
		give_verdict();
	end
endmodule
